/* File: bcs_defines.svh */
// Register offsets, field positions and reset values for the board control and status bank.
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH
`define BCS_CTRL0_ADDR 32'h1000_0001
`define BCS_STATUS_ADDR 32'h1000_0003
`define BCS_CTRL0_RESET 8'h00
`define BCS_BOARD_OUT_RESET 7'h60
`define BCS_CTL_FAULT 0
`define BCS_CTL_SEL 1
`define BCS_CTL_CLK 2
`define BCS_CTL_DIN 3
`define BCS_STS_DOUT 5
`define BCS_STS_DMA_READY_FLAG 4
`define BCS_SYNC_STAGES 2
`endif

/* File: bcs_pkg.sv */
// Types shared by the board control and status bank.
package bcs_pkg;
  // Outputs facing the board: lamps, system-fail and serial memory lines.
  typedef struct packed {
    logic faultLampOn;
    logic sysFailOn;
    logic dmaLampOn;
    logic vmeLampOn;
    logic serialMemSelBit;
    logic serialMemClkBit;
    logic serialMemDinBit;
  } bcs_board_out_t;
  // Raw inputs from pins and other board logic.
  typedef struct packed {
    logic [5:0] boardSelectSwitches;
    logic serialMemDoutBit;
    logic dmaReadyFlag;
  } bcs_pin_in_t;
  typedef enum logic [1:0] {
    BCS_SEL_NONE = 2'b00,
    BCS_SEL_CTRL = 2'b01,
    BCS_SEL_STATUS = 2'b10
  } bcs_sel_t;
endpackage

/* File: bcs_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module bcs_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Levels in and out.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule // bcs_sync

/* File: bcs_regs.sv */
// Board control and status register pair with lamps, system-fail and serial memory lines.
// Operation
// - Control bit 0 low lights fault lamp and asserts system-fail; high releases both.
// - Fault control bit resets to 0, so lamp lit until software writes 1.
// - DMA lamp is on in the cycle after each cycle the DMA controller owns the bus.
// - Bus lamp is on while the board is master on the backplane bus.
// - Serial memory select, clock, data-in follow control bits 1, 2, 3.
// - Select bit 0 deselects, 1 selects; it resets to 0.
// - Data-in bit drives the serial memory data input directly.
// - Clock bit drives the serial memory clock directly, no hardware clocking.
// - Serial memory data-out reads as status bit 5.
// - Status holds switches 1-4 in bits 0-3, ready flag 4, switches 5-6 in 6-7.
// - Switch bit reads 0 when on, 1 when off.
`timescale 1ns/1ps
`include "bcs_defines.svh"
module bcs_regs (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Bus ownership from same-clock logic.
  input wire logic dmaOwnsBus,
  input wire logic vmeMasterActive,
  // Board pins.
  input wire bcs_pkg::bcs_pin_in_t pinIn,
  output bcs_pkg::bcs_board_out_t boardOut
);
  logic [7:0] ctrl_q;
  logic [7:0] pinSync;
  logic [7:0] statusWord;
  logic [7:0] rdata_d;
  bcs_pkg::bcs_sel_t readSel;
  bcs_pkg::bcs_board_out_t boardOut_d;

  // Switches and serial data come from pins, so they are synchronised first.
  bcs_sync #(.WIDTH(8)) uSync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  // Address decoding; the status address is deliberately absent from the write path.
  function automatic bcs_pkg::bcs_sel_t decodeAddr(input logic [31:0] a);
    if (a == `BCS_CTRL0_ADDR) begin
      decodeAddr = bcs_pkg::BCS_SEL_CTRL;
    end else if (a == `BCS_STATUS_ADDR) begin
      decodeAddr = bcs_pkg::BCS_SEL_STATUS;
    end else begin
      decodeAddr = bcs_pkg::BCS_SEL_NONE;
    end
  endfunction

  assign readSel = decodeAddr(regAddr);

  // Status layout; switch levels pass through unchanged, low meaning switch on.
  assign statusWord = {pinSync[7:6], pinSync[1], pinSync[0], pinSync[5:2]};

  // Read mux; unmapped addresses return zero.
  assign rdata_d = !regRead ? 8'h00 :
                   (readSel == bcs_pkg::BCS_SEL_CTRL) ? ctrl_q :
                   (readSel == bcs_pkg::BCS_SEL_STATUS) ? statusWord : 8'h00;

  // Board outputs come from control bits and bus ownership levels.
  assign boardOut_d.faultLampOn = ~ctrl_q[`BCS_CTL_FAULT];
  assign boardOut_d.sysFailOn = ~ctrl_q[`BCS_CTL_FAULT];
  assign boardOut_d.dmaLampOn = dmaOwnsBus;
  assign boardOut_d.vmeLampOn = vmeMasterActive;
  assign boardOut_d.serialMemSelBit = ctrl_q[`BCS_CTL_SEL];
  assign boardOut_d.serialMemClkBit = ctrl_q[`BCS_CTL_CLK];
  assign boardOut_d.serialMemDinBit = ctrl_q[`BCS_CTL_DIN];

  // Control register; reset lights the lamp and deselects the memory.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `BCS_CTRL0_RESET;
    end else if (regWrite && readSel == bcs_pkg::BCS_SEL_CTRL) begin
      ctrl_q <= regWdata;
    end
  end

  // Outputs are registered, adding one cycle of lag to each level.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
      boardOut <= `BCS_BOARD_OUT_RESET;
    end else begin
      regRdata <= rdata_d;
      boardOut <= boardOut_d;
    end
  end

  // Helper decodes for the checks, written apart from the datapath decode so one slip is not mirrored.
  logic ctrlWriteHit;
  logic statusWriteHit;
  logic ctrlReadHit;
  logic statusReadHit;
  logic otherReadHit;
  logic [1:0] syncAge_q;
  logic [1:0] syncAge_d;

  // Strobes qualified by the two register addresses.
  assign ctrlWriteHit = regWrite && (regAddr == `BCS_CTRL0_ADDR);
  assign statusWriteHit = regWrite && (regAddr == `BCS_STATUS_ADDR);
  assign ctrlReadHit = regRead && (regAddr == `BCS_CTRL0_ADDR);
  assign statusReadHit = regRead && (regAddr == `BCS_STATUS_ADDR);
  assign otherReadHit = regRead && !ctrlReadHit && !statusReadHit;

  // Edges since reset, saturating at three; the synchroniser needs two of them before pins are valid.
  assign syncAge_d = (syncAge_q == 2'h3) ? syncAge_q : syncAge_q + 2'h1;

  // Age counter used by the checks only; the datapath never reads it.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncAge_q <= 2'h0;
    end else begin
      syncAge_q <= syncAge_d;
    end
  end

  // A control write that releases the fault pair, and one that lights it.
  sequence s_fault_release;
    ctrlWriteHit && regWdata[`BCS_CTL_FAULT];
  endsequence
  sequence s_fault_light;
    ctrlWriteHit && !regWdata[`BCS_CTL_FAULT];
  endsequence

  // A control write followed at once by a control read of the same register.
  sequence s_ctrl_write_read;
    ctrlWriteHit ##1 ctrlReadHit;
  endsequence

  // A write that lands on the read-only status address.
  sequence s_status_write;
    statusWriteHit && !ctrlWriteHit;
  endsequence

  // Fault lamp and system-fail follow the inverse of control bit 0 one edge late.
  a_fault_lamp: assert property (@(posedge ref_clk) disable iff (!rstn)
    boardOut.faultLampOn == !$past(ctrl_q[`BCS_CTL_FAULT]))
    else $error("fault lamp mismatch");
  a_sysfail_pair: assert property (@(posedge ref_clk) disable iff (!rstn)
    boardOut.sysFailOn == boardOut.faultLampOn)
    else $error("system-fail differs from fault lamp");
  a_fault_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_fault_release |->
    ##2 !boardOut.faultLampOn && !boardOut.sysFailOn)
    else $error("fault lamp not cleared");
  a_fault_relight: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_fault_light |->
    ##2 boardOut.faultLampOn && boardOut.sysFailOn)
    else $error("fault lamp not lit");

  // A rising bit puts the lamp out on the next edge, a falling one lights it.
  a_fault_off_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(ctrl_q[`BCS_CTL_FAULT]) |=>
    $fell(boardOut.faultLampOn))
    else $error("fault lamp did not go out");
  a_fault_on_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(ctrl_q[`BCS_CTL_FAULT]) |=>
    $rose(boardOut.faultLampOn))
    else $error("fault lamp did not light");

  // Out of reset the lamp is lit and the memory deselected, and the lamp holds until written.
  a_reset_state: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncAge_q == 2'h0 |->
    ctrl_q == `BCS_CTRL0_RESET && boardOut == `BCS_BOARD_OUT_RESET)
    else $error("state after reset wrong");
  a_fault_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ctrl_q[`BCS_CTL_FAULT] && !ctrlWriteHit |=>
    !ctrl_q[`BCS_CTL_FAULT] && boardOut.faultLampOn)
    else $error("fault lamp went out unwritten");

  // Bus ownership levels reach the green lamps one edge late, both ways.
  a_dma_lamp: assert property (@(posedge ref_clk) disable iff (!rstn)
    dmaOwnsBus |=>
    boardOut.dmaLampOn)
    else $error("dma lamp off");
  a_dma_lamp_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    !dmaOwnsBus |=>
    !boardOut.dmaLampOn)
    else $error("dma lamp on while idle");
  a_vme_lamp: assert property (@(posedge ref_clk) disable iff (!rstn)
    vmeMasterActive |=>
    boardOut.vmeLampOn)
    else $error("bus lamp off");
  a_vme_lamp_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    !vmeMasterActive |=>
    !boardOut.vmeLampOn)
    else $error("bus lamp on while idle");

  // Lamp edges follow ownership edges, so the lamp brightness tracks the duty of the bus.
  a_dma_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(dmaOwnsBus) |=>
    $rose(boardOut.dmaLampOn))
    else $error("dma lamp missed a rise");
  a_dma_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(dmaOwnsBus) |=>
    $fell(boardOut.dmaLampOn))
    else $error("dma lamp missed a fall");
  a_vme_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(vmeMasterActive) |=>
    $rose(boardOut.vmeLampOn))
    else $error("bus lamp missed a rise");
  a_vme_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(vmeMasterActive) |=>
    $fell(boardOut.vmeLampOn))
    else $error("bus lamp missed a fall");

  // Each serial memory line mirrors its control bit one edge late.
  a_sel_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    boardOut.serialMemSelBit == $past(ctrl_q[`BCS_CTL_SEL]))
    else $error("select line wrong");
  a_clk_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    boardOut.serialMemClkBit == $past(ctrl_q[`BCS_CTL_CLK]))
    else $error("serial clock line wrong");
  a_din_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    boardOut.serialMemDinBit == $past(ctrl_q[`BCS_CTL_DIN]))
    else $error("data-in line wrong");
  a_serial_lines: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlWriteHit |-> ##2
    boardOut.serialMemSelBit == $past(regWdata[`BCS_CTL_SEL], 2)
    && boardOut.serialMemClkBit == $past(regWdata[`BCS_CTL_CLK], 2)
    && boardOut.serialMemDinBit == $past(regWdata[`BCS_CTL_DIN], 2))
    else $error("serial lines wrong");

  // The serial clock only moves when software moves its bit; there is no clock of our own.
  a_clk_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(ctrl_q[`BCS_CTL_CLK]) |=>
    $rose(boardOut.serialMemClkBit))
    else $error("serial clock missed a rise");
  a_clk_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(ctrl_q[`BCS_CTL_CLK]) |=>
    $fell(boardOut.serialMemClkBit))
    else $error("serial clock missed a fall");
  a_clk_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncAge_q == 2'h0 |->
    !boardOut.serialMemClkBit)
    else $error("serial clock high after reset");

  // Data-in edges follow the bit the same way.
  a_din_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(ctrl_q[`BCS_CTL_DIN]) |=>
    $rose(boardOut.serialMemDinBit))
    else $error("data-in missed a rise");
  a_din_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(ctrl_q[`BCS_CTL_DIN]) |=>
    $fell(boardOut.serialMemDinBit))
    else $error("data-in missed a fall");
  a_din_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncAge_q == 2'h0 |->
    !boardOut.serialMemDinBit)
    else $error("data-in high after reset");

  // The select line stays low after reset and whenever software clears its bit.
  a_sel_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncAge_q == 2'h0 |->
    !boardOut.serialMemSelBit)
    else $error("memory selected after reset");
  a_sel_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlWriteHit && !regWdata[`BCS_CTL_SEL] |->
    ##2 !boardOut.serialMemSelBit)
    else $error("memory not deselected");
  a_sel_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(ctrl_q[`BCS_CTL_SEL]) |=>
    $rose(boardOut.serialMemSelBit))
    else $error("select missed a rise");
  a_sel_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(ctrl_q[`BCS_CTL_SEL]) |=>
    $fell(boardOut.serialMemSelBit))
    else $error("select missed a fall");

  // Status reads return the synchronised pins in their fixed places.
  a_status_dout: assert property (@(posedge ref_clk) disable iff (!rstn)
    statusReadHit |=>
    regRdata[`BCS_STS_DOUT] == $past(pinSync[1]))
    else $error("status data-out bit wrong");
  a_status_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    statusReadHit |=>
    regRdata[`BCS_STS_DMA_READY_FLAG] == $past(pinSync[0]))
    else $error("status ready bit wrong");
  a_switch_bits: assert property (@(posedge ref_clk) disable iff (!rstn)
    statusReadHit |=>
    {regRdata[7:6], regRdata[3:0]} == $past(pinSync[7:2]))
    else $error("switch bits wrong");

  // Pins read as zero until the stages fill, then arrive two edges late.
  a_sync_fill: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncAge_q < 2'h2 |->
    pinSync == 8'h00)
    else $error("synchroniser not cleared by reset");
  a_sync_delay: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncAge_q == 2'h3 |->
    pinSync == $past(pinIn, 2))
    else $error("synchroniser delay wrong");

  // The status address takes no writes, and the control byte holds between writes.
  a_status_ro: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_status_write |=>
    $stable(ctrl_q))
    else $error("status write changed state");
  a_ctrl_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ctrlWriteHit |=>
    $stable(ctrl_q))
    else $error("control changed without a write");

  // Control writes land whole and read back whole on the next cycle.
  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlWriteHit |=>
    ctrl_q == $past(regWdata))
    else $error("control write lost bits");
  a_ctrl_readback: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_ctrl_write_read |=>
    regRdata == $past(regWdata, 2))
    else $error("control readback wrong");
  a_ctrl_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlReadHit |=>
    regRdata == $past(ctrl_q))
    else $error("control read wrong");
  a_upper_bits: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlReadHit |=>
    regRdata[7:4] == $past(ctrl_q[7:4]))
    else $error("upper control bits lost");

  // Read data stand for one cycle; idle cycles and unmapped addresses show zero.
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    !regRead |=>
    regRdata == 8'h00)
    else $error("read data outside a read");
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    otherReadHit |=>
    regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_once: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrlReadHit ##1 !regRead |=>
    regRdata == 8'h00)
    else $error("read data stood too long");
endmodule // bcs_regs

/* File: bcs_board_model.sv */
// Far-side board model: serial memory, board select switches and ready flag.
`timescale 1ns/1ps
module bcs_board_model (
  // Serial memory lines from the block.
  input wire logic sel,
  input wire logic sclk,
  input wire logic din,
  // Switches and ready flag set by the bench.
  input wire logic [5:0] sw,
  input wire logic rdy,
  // Pin levels toward the block.
  output bcs_pkg::bcs_pin_in_t pinIn
);
  logic memBit_q = 1'b0;
  // A one-bit echo memory: data in is captured on each clock rise while selected.
  always @(posedge sclk) begin
    if (sel) begin
      memBit_q <= din;
    end
  end
  // Deselected, data out is undriven, so it shows the inverse instead of a stale level.
  assign pinIn = {sw, sel ? memBit_q : ~memBit_q, rdy};
endmodule // bcs_board_model

/* File: board_control_status_regs_test.sv */
// Self-checking bench for the board control and status bank.
`timescale 1ns/1ps
`include "bcs_defines.svh"
module board_control_status_regs_test;
  logic ref_clk = 0, rstn = 0, regWrite = 0, regRead = 0, dmaOwnsBus = 0, vmeMasterActive = 0, rdSeen = 0, rdy = 0;
  logic [31:0] regAddr = '0;
  logic [7:0] regWdata = '0, regRdata, ctl, st;
  logic [5:0] sw = '0;
  logic [7:0] expQ[$];
  int n_mismatch = 0, n_tests = 0;
  bcs_pkg::bcs_pin_in_t pinIn;
  bcs_pkg::bcs_board_out_t boardOut;
  bcs_regs bcs_regs_inst(.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .dmaOwnsBus(dmaOwnsBus),
    .vmeMasterActive(vmeMasterActive), .pinIn(pinIn), .boardOut(boardOut));
  bcs_board_model bcs_board_model_inst(.sel(boardOut.serialMemSelBit), .sclk(boardOut.serialMemClkBit),
    .din(boardOut.serialMemDinBit), .sw(sw), .rdy(rdy), .pinIn(pinIn));
  // Free-running 25 MHz clock.
  initial forever #20 ref_clk = ~ref_clk;
  task automatic cmpRd(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpOut(input logic [6:0] exp);
    n_tests++;
    if (boardOut !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: board outputs %b, expected %b", $time, boardOut, exp);
    end
  endtask
  // Transfer tasks leave their strobe up, so back-to-back calls never assign one signal twice in a step.
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regRead <= 1'b0;
    regWrite <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic idle;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Lamps and system-fail are active high; the fault pair is lit while control bit 0 is low.
  function automatic logic [6:0] expOut(input logic [7:0] c, input logic d, input logic v);
    return {~c[0], ~c[0], d, v, c[1], c[2], c[3]};
  endfunction
  // Read data stands only in the cycle after the strobe, so it is sampled one edge later.
  always @(posedge ref_clk) begin
    rdSeen <= regRead;
    if (rdSeen) begin
      cmpRd(regRdata, expQ.pop_front());
    end
  end
  // Watchdog: a hung run counts as a mismatch.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'ha488_f1b1));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1 cmpOut(7'h60);
    rd(`BCS_CTRL0_ADDR, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      ctl = $urandom;
      ctl[0] = i[0];
      wr(`BCS_CTRL0_ADDR, ctl);
      rd(`BCS_CTRL0_ADDR, ctl);
      idle();
      #1 cmpOut(expOut(ctl, 1'b0, 1'b0));
    end
    $display("control test done");
    for (int d = 0; d < 2; d++) begin
      sw <= 6'($urandom);
      rdy <= 1'($urandom);
      wr(`BCS_CTRL0_ADDR, {4'h0, d[0], 3'h3});
      wr(`BCS_CTRL0_ADDR, {4'h0, d[0], 3'h7});
      idle();
      repeat (3) @(posedge ref_clk);
      // Switch levels stay raw; startup code decodes sw[5:4] as boot mode and sw[3:0] as board number.
      st = {sw[5:4], d[0], rdy, sw[3:0]};
      rd(`BCS_STATUS_ADDR, st);
      wr(`BCS_STATUS_ADDR, ~st);
      rd(`BCS_STATUS_ADDR, st);
      rd(32'h1000_0002, 8'h00);
    end
    $display("status test done");
    idle();
    for (int i = 0; i < 4; i++) begin
      dmaOwnsBus <= i[0];
      vmeMasterActive <= i[1];
      repeat (2) @(posedge ref_clk);
      #1 cmpOut(expOut(8'h0F, i[0], i[1]));
    end
    $display("lamp test done");
    repeat (3) @(posedge ref_clk);
    end_sim();
  end
endmodule // board_control_status_regs_test
